// ---- bcr_pkg.sv ----
// Purpose: Shared types and constants for the block call / return sequencer
// Assumes: One instruction clock; block stack depth fixed
// Notes:   Status word and block-stack frame travel as packed structs
package bcr_pkg;

  localparam int unsigned SEL_W      = 16;
  localparam int unsigned REL_W      = 16;
  localparam int unsigned LDA_W      = 16;
  localparam int unsigned REG_W      = 32;
  localparam int unsigned DEPTH      = 8;
  localparam int unsigned PTR_W      = 4;
  localparam logic [PTR_W-1:0] PTR_RST   = 4'h0;
  localparam logic [PTR_W-1:0] PTR_FULL  = 4'h8;
  localparam logic [LDA_W-1:0] LDA_RST   = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RST   = 16'h0000;
  localparam logic [REL_W-1:0] REL_RST   = 16'h0000;
  localparam logic [REG_W-1:0] REG_RST   = 32'h0000_0000;

  typedef enum logic [1:0] {
    BCR_KIND_FUNC,
    BCR_KIND_UNIT,
    BCR_KIND_SYS_FUNC,
    BCR_KIND_SYS_UNIT
  } bcr_kind_t;

  // Status word bits touched or preserved
  typedef struct packed {
    logic binary_result_bit;
    logic cc1;
    logic cc0;
    logic ov;
    logic stored_overflow_bit;
    logic or_pending;
    logic bit_state_flag;
    logic logic_result_bit;
    logic first_check_bit;
  } bcr_status_t;

  localparam bcr_status_t STATUS_RST = '0;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [REL_W-1:0] rel;
  } bcr_addr_t;

  // One block-stack frame
  typedef struct packed {
    bcr_addr_t        ret;
    logic [SEL_W-1:0] shr_sel;
    logic [SEL_W-1:0] di_sel;
    logic             relay_area_active_flag;
    logic [LDA_W-1:0] lda_base;
    logic             is_sys;
    logic [REG_W-1:0] accu1;
    logic [REG_W-1:0] accu2;
  } bcr_frame_t;

  typedef struct packed {
    logic [REG_W-1:0] accu1;
    logic [REG_W-1:0] accu2;
  } bcr_regs_t;

  // Status word update shared by call and block end
  function automatic bcr_status_t bcr_call_status(input bcr_status_t s);
    bcr_status_t r;
    r = s;
    r.stored_overflow_bit = 1'b0;
    r.or_pending          = 1'b0;
    r.first_check_bit     = 1'b0;
    r.bit_state_flag      = 1'b1;
    return r;
  endfunction

endpackage

// ---- bcr_prog_model.sv ----
// Purpose: Program counter model in front of the sequencer
// Assumes: One instruction per clock; a loaded address takes effect next cycle
// Notes:   Offers the address after the current instruction as the return point
`timescale 1ns/10ps
module bcr_prog_model (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               pc_load,
  input  wire bcr_pkg::bcr_addr_t pc_addr,
  output bcr_pkg::bcr_addr_t      next_addr
);
  import bcr_pkg::*;
  bcr_addr_t pc_q;
  // -----------------------------------------------------------------
  // Program counter
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= '0;
    end else if (pc_load) begin
      pc_q <= pc_addr;
    end else begin
      pc_q.rel <= pc_q.rel + 16'h0001;
    end
  end
  // Calling code is well formed: instance blocks exist, bindings typed and complete
  assign next_addr = '{sel: pc_q.sel, rel: pc_q.rel + 16'h0001};
endmodule // bcr_prog_model

// ---- bcr_sequencer.sv ----
// Purpose: Carries out the unconditional block end and the block call
// Assumes: Caller presents one instruction per pulse; instance block exists
// Notes:   Block stack is an internal array of return frames
`timescale 1ns/10ps
module bcr_sequencer (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      call_req,
  input  wire bcr_pkg::bcr_kind_t        call_kind,
  input  wire bcr_pkg::bcr_addr_t        call_target,
  input  wire logic [bcr_pkg::SEL_W-1:0] call_inst_sel,
  input  wire bcr_pkg::bcr_addr_t        next_addr,
  input  wire logic [bcr_pkg::LDA_W-1:0] callee_lda_size,
  input  wire logic                      block_end_req,
  input  wire logic                      open_data_block_ref_req,
  input  wire logic [bcr_pkg::SEL_W-1:0] open_data_block_ref_sel,
  input  wire logic                      relay_area_set,
  input  wire logic                      relay_area_clr,
  input  wire bcr_pkg::bcr_regs_t        regs_in,
  input  wire bcr_pkg::bcr_status_t      status_in,
  output logic                           pc_load,
  output bcr_pkg::bcr_addr_t             pc_addr,
  output logic [bcr_pkg::SEL_W-1:0]      data_block_ref_sel,
  output logic [bcr_pkg::SEL_W-1:0]      di_sel,
  output logic                           relay_area_active_flag,
  output logic [bcr_pkg::LDA_W-1:0]      lda_base,
  output logic [bcr_pkg::LDA_W-1:0]      lda_top,
  output bcr_pkg::bcr_status_t           status_out,
  output logic                           regs_load,
  output bcr_pkg::bcr_regs_t             regs_out,
  output logic [bcr_pkg::PTR_W-1:0]      stack_depth,
  output logic                           stack_fault
);
  import bcr_pkg::*;

  bcr_frame_t             stack_q [DEPTH];
  bcr_frame_t             push_frame;
  logic                   do_push;
  logic                   do_pop;
  bcr_frame_t             top;
  logic                   pc_load_q,   pc_load_d;
  bcr_addr_t              pc_addr_q,   pc_addr_d;
  logic [SEL_W-1:0]       shr_q,       shr_d;
  logic [SEL_W-1:0]       di_q,        di_d;
  logic                   relay_q,     relay_d;
  logic [LDA_W-1:0]       base_q,      base_d;
  logic [LDA_W-1:0]       top_q,       top_d;
  bcr_status_t            st_q,        st_d;
  logic                   rl_q,        rl_d;
  bcr_regs_t              ro_q,        ro_d;
  logic [PTR_W-1:0]       ptr_q,       ptr_d;
  logic                   flt_q,       flt_d;

  // ---------------------------------------------------------------
  // Call and block-end sequencing
  // ---------------------------------------------------------------
  assign top = stack_q[ptr_q[PTR_W-2:0] - 3'h1];

  always_comb begin
    pc_load_d  = 1'b0;
    pc_addr_d  = pc_addr_q;
    shr_d      = shr_q;
    di_d       = di_q;
    relay_d    = relay_q;
    base_d     = base_q;
    top_d      = top_q;
    st_d       = st_q;
    rl_d       = 1'b0;
    ro_d       = ro_q;
    ptr_d      = ptr_q;
    flt_d      = 1'b0;
    do_push    = 1'b0;
    do_pop     = 1'b0;
    push_frame = '0;
    if (open_data_block_ref_req) begin
      shr_d = open_data_block_ref_sel;
    end
    if (relay_area_set) begin
      relay_d = 1'b1;
    end else if (relay_area_clr) begin
      relay_d = 1'b0;
    end
    // Result bit and conditions are not consulted
    if (call_req) begin
      if (ptr_q == PTR_FULL) begin
        flt_d = 1'b1;
      end else begin
        push_frame.ret    = next_addr;
        push_frame.shr_sel = shr_q;
        push_frame.di_sel = di_q;
        push_frame.relay_area_active_flag = relay_q;
        push_frame.lda_base = base_q;
        push_frame.is_sys = (call_kind == BCR_KIND_SYS_FUNC) ||
                            (call_kind == BCR_KIND_SYS_UNIT);
        push_frame.accu1  = regs_in.accu1;
        push_frame.accu2  = regs_in.accu2;
        do_push   = 1'b1;
        ptr_d     = ptr_q + 4'h1;
        relay_d   = 1'b0;
        base_d    = top_q;
        top_d     = top_q + callee_lda_size;
        // Only unit calls switch the instance block to call_inst_sel; function calls keep the caller's
        if (call_kind == BCR_KIND_UNIT || call_kind == BCR_KIND_SYS_UNIT) begin
          di_d = call_inst_sel;
        end
        pc_load_d = 1'b1;
        pc_addr_d = call_target;
        st_d      = bcr_call_status(status_in);
      end
    end else if (block_end_req) begin
      if (ptr_q == PTR_RST) begin
        flt_d = 1'b1;
      end else begin
        do_pop    = 1'b1;
        ptr_d     = ptr_q - 4'h1;
        pc_load_d = 1'b1;
        pc_addr_d = top.ret;
        top_d     = base_q;
        base_d    = top.lda_base;
        shr_d     = top.shr_sel;
        di_d      = top.di_sel;
        relay_d   = top.relay_area_active_flag;
        // Result bit passes through untouched by the status helper
        st_d      = bcr_call_status(status_in);
        rl_d      = top.is_sys;
        ro_d      = '{accu1: top.accu1, accu2: top.accu2};
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_load_q <= 1'b0;
      pc_addr_q <= '{sel: SEL_RST, rel: REL_RST};
      shr_q     <= SEL_RST;
      di_q      <= SEL_RST;
      relay_q   <= 1'b0;
      base_q    <= LDA_RST;
      top_q     <= LDA_RST;
      st_q      <= STATUS_RST;
      rl_q      <= 1'b0;
      ro_q      <= '{accu1: REG_RST, accu2: REG_RST};
      ptr_q     <= PTR_RST;
      flt_q     <= 1'b0;
    end else begin
      pc_load_q <= pc_load_d;
      pc_addr_q <= pc_addr_d;
      shr_q     <= shr_d;
      di_q      <= di_d;
      relay_q   <= relay_d;
      base_q    <= base_d;
      top_q     <= top_d;
      st_q      <= st_d;
      rl_q      <= rl_d;
      ro_q      <= ro_d;
      ptr_q     <= ptr_d;
      flt_q     <= flt_d;
    end
  end

  // ---------------------------------------------------------------
  // Block stack storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (do_push) begin
      stack_q[ptr_q[PTR_W-2:0]] <= push_frame;
    end
  end

  assign pc_load                = pc_load_q;
  assign pc_addr                = pc_addr_q;
  assign data_block_ref_sel     = shr_q;
  assign di_sel                 = di_q;
  assign relay_area_active_flag = relay_q;
  assign lda_base               = base_q;
  assign lda_top                = top_q;
  assign status_out             = st_q;
  assign regs_load              = rl_q;
  assign regs_out               = ro_q;
  assign stack_depth            = ptr_q;
  assign stack_fault            = flt_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_call_ok;
    call_req && ptr_q != PTR_FULL;
  endsequence

  sequence s_end_ok;
    !call_req && block_end_req && ptr_q != PTR_RST;
  endsequence

  a_call_status_bits: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_ok |=> !st_q.stored_overflow_bit && !st_q.or_pending && !st_q.first_check_bit
                  && st_q.bit_state_flag)
    else $error("call status bits wrong");

  a_call_relay_off: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_ok |=> !relay_q && lda_base == $past(top_q) && pc_load_q)
    else $error("call did not disable relay or allocate local data");

  a_call_unconditional: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_ok |=> pc_addr_q == $past(call_target))
    else $error("call not taken");

  a_end_returns: assert property (@(posedge clk) disable iff (sys_rst)
    s_end_ok |=> pc_load_q && pc_addr_q == $past(top.ret))
    else $error("block end did not return");

  a_end_restore_refs: assert property (@(posedge clk) disable iff (sys_rst)
    s_end_ok |=> shr_q == $past(top.shr_sel) && di_q == $past(top.di_sel))
    else $error("data blocks not reopened");

  a_end_frees_lda: assert property (@(posedge clk) disable iff (sys_rst)
    s_end_ok |=> lda_top == $past(base_q) && lda_base == $past(top.lda_base))
    else $error("local data not released");

  a_end_keeps_result: assert property (@(posedge clk) disable iff (sys_rst)
    s_end_ok |=> st_q.logic_result_bit == $past(status_in.logic_result_bit)
                 && relay_q == $past(top.relay_area_active_flag))
    else $error("result bit or relay flag wrong on return");

  a_call_end_depth: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_ok ##1 s_end_ok |=> stack_depth == $past(stack_depth, 2))
    else $error("stack depth unbalanced");

  a_sys_regs_back: assert property (@(posedge clk) disable iff (sys_rst)
    s_end_ok |=> regs_load == $past(top.is_sys)
                 && regs_out == $past({top.accu1, top.accu2}))
    else $error("system call registers not restored");

endmodule // bcr_sequencer

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the block call / return sequencer
// Assumes: Inputs change at the falling edge; outputs read one cycle after a request
// Notes:   Nested calls, system register restore, stack limits
`timescale 1ns/10ps
module tb_top;
  import bcr_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, call_req = 1'b0, block_end_req = 1'b0;
  logic        open_data_block_ref_req = 1'b0, relay_area_set = 1'b0, relay_area_clr = 1'b0;
  logic        pc_load, relay_area_active_flag, regs_load, stack_fault;
  bcr_kind_t   call_kind = BCR_KIND_FUNC;
  bcr_addr_t   call_target = '0, next_addr, pc_addr;
  logic [15:0] call_inst_sel = '0, callee_lda_size = '0, open_data_block_ref_sel = '0;
  logic [15:0] data_block_ref_sel, di_sel, lda_base, lda_top;
  bcr_regs_t   regs_in = '0, regs_out;
  bcr_status_t status_in = '0, status_out;
  logic [3:0]  stack_depth;
  int          failures = 0, checks_done = 0;

  always #10 clk = ~clk;

  bcr_sequencer i_dut (.clk, .sys_rst, .call_req, .call_kind, .call_target, .call_inst_sel,
    .next_addr, .callee_lda_size, .block_end_req, .open_data_block_ref_req,
    .open_data_block_ref_sel, .relay_area_set, .relay_area_clr, .regs_in, .status_in,
    .pc_load, .pc_addr, .data_block_ref_sel, .di_sel,
    .relay_area_active_flag, .lda_base, .lda_top, .status_out, .regs_load, .regs_out,
    .stack_depth, .stack_fault);
  bcr_prog_model i_prog (.clk, .sys_rst, .pc_load, .pc_addr, .next_addr);

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request held through the taking edge; left high for back-to-back use
  task automatic op(input logic is_call, input bcr_kind_t k, input logic [15:0] tsel,
                    input logic [15:0] inst, input logic [15:0] size);
    call_req = is_call;
    block_end_req = !is_call;
    call_kind = k;
    call_target = '{sel: tsel, rel: 16'h0000};
    call_inst_sel = inst;
    callee_lda_size = size;
    @(negedge clk);
  endtask

  task automatic idle();
    call_req = 1'b0;
    block_end_req = 1'b0;
    @(negedge clk);
  endtask

  task automatic s_nest();
    bcr_addr_t r1, r2;
    open_data_block_ref_req = 1'b1;
    open_data_block_ref_sel = 16'h0a0a;
    relay_area_set = 1'b1;
    @(negedge clk);
    open_data_block_ref_req = 1'b0;
    relay_area_set = 1'b0;
    status_in = 9'h1ff;
    r1 = next_addr;
    op(1'b1, BCR_KIND_UNIT, 16'h0011, 16'h00d1, 16'h0020);
    chk("pc_load", 64'h1, pc_load);
    chk("pc_addr", 64'h0011_0000, pc_addr);
    chk("relay", 64'h0, relay_area_active_flag);
    chk("lda", 64'h0000_0020, {lda_base, lda_top});
    chk("sel", 64'h0a0a_00d1, {data_block_ref_sel, di_sel});
    chk("status", 64'h1e6, status_out);
    regs_in = '{accu1: 32'h1234_5678, accu2: 32'h9abc_def0};
    status_in = 9'h000;
    r2 = next_addr;
    op(1'b1, BCR_KIND_SYS_FUNC, 16'h0022, 16'h00e2, 16'h0010);
    chk("lda", 64'h0020_0030, {lda_base, lda_top});
    chk("status", 64'h004, status_out);
    chk("depth", 64'h2, stack_depth);
    regs_in = '0;
    status_in = 9'h003;
    op(1'b0, BCR_KIND_FUNC, 16'h0000, 16'h0000, 16'h0000);
    chk("pc_addr", r2, pc_addr);
    chk("regs_load", 64'h1, regs_load);
    chk("regs_out", 64'h1234_5678_9abc_def0, regs_out);
    chk("lda", 64'h0000_0020, {lda_base, lda_top});
    chk("sel", 64'h0a0a_00d1, {data_block_ref_sel, di_sel});
    chk("status", 64'h006, status_out);
    chk("depth", 64'h1, stack_depth);
    status_in = 9'h000;
    op(1'b0, BCR_KIND_FUNC, 16'h0000, 16'h0000, 16'h0000);
    chk("pc_addr", r1, pc_addr);
    chk("relay", 64'h1, relay_area_active_flag);
    chk("sel", 64'h0a0a_0000, {data_block_ref_sel, di_sel});
    chk("lda", 64'h0, {lda_base, lda_top});
    chk("regs_load", 64'h0, regs_load);
    idle();
  endtask

  task automatic s_limits();
    int i;
    op(1'b0, BCR_KIND_FUNC, 16'h0000, 16'h0000, 16'h0000);
    chk("fault", 64'h1, stack_fault);
    idle();
    repeat (2) @(negedge clk);
    chk("pc_load", 64'h0, pc_load);
    chk("depth", 64'h0, stack_depth);
    for (i = 0; i < 8; i++) begin
      op(1'b1, BCR_KIND_FUNC, i[15:0], 16'h0000, 16'h0004);
    end
    chk("depth", 64'h8, stack_depth);
    chk("lda", 64'h001c_0020, {lda_base, lda_top});
    op(1'b1, BCR_KIND_SYS_UNIT, 16'h0033, 16'h00f3, 16'h0004);
    chk("fault", 64'h1, stack_fault);
    chk("lda", 64'h001c_0020, {lda_base, lda_top});
    for (i = 0; i < 8; i++) begin
      op(1'b0, BCR_KIND_FUNC, 16'h0000, 16'h0000, 16'h0000);
    end
    chk("depth", 64'h0, stack_depth);
    chk("lda", 64'h0, {lda_base, lda_top});
    regs_in = '{accu1: 32'h1357_9bdf, accu2: 32'h2468_ace0};
    op(1'b1, BCR_KIND_SYS_UNIT, 16'h0044, 16'h00f4, 16'h0008);
    chk("sel", 64'h0a0a_00f4, {data_block_ref_sel, di_sel});
    chk("lda", 64'h0000_0008, {lda_base, lda_top});
    regs_in = '0;
    op(1'b0, BCR_KIND_FUNC, 16'h0000, 16'h0000, 16'h0000);
    chk("regs_load", 64'h1, regs_load);
    chk("regs_out", 64'h1357_9bdf_2468_ace0, regs_out);
    chk("sel", 64'h0a0a_0000, {data_block_ref_sel, di_sel});
    idle();
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    s_nest();
    s_limits();
    conclude();
  end

  initial begin
    #20000;
    failures++;
    conclude();
  end
endmodule // tb_top
